//--- logic/bfp_pkg.sv
// package for the boot flash read-while-write protection block
package bfp_pkg;
    // apb register offsets (byte addresses)
    localparam logic [11:0] OFF_CTRL    = 12'h000;
    localparam logic [11:0] OFF_STATUS  = 12'h004;
    localparam logic [11:0] OFF_LOCK    = 12'h008;
    localparam logic [11:0] OFF_FUSE    = 12'h00c;
    // ctrl field positions
    localparam int CTRL_REENABLE  = 0;
    localparam int CTRL_VEC_BOOT  = 1;
    // status field positions
    localparam int ST_BUSY_FLAG   = 0;
    localparam int ST_STALL       = 1;
    localparam int ST_OP_ACTIVE   = 2;
    localparam int ST_REFUSED     = 3;
    // lock field positions: application pair in [1:0], loader pair in [3:2]
    localparam int LK_APP_LO      = 0;
    localparam int LK_APP_HI      = 1;
    localparam int LK_LDR_LO      = 2;
    localparam int LK_LDR_HI      = 3;
    // reset values: unprogrammed lock bits read as one
    localparam logic [3:0] LOCK_RESET = 4'hf;
    localparam logic [1:0] PAIR_FREE  = 2'h3;
    localparam logic [1:0] PAIR_NOWR  = 2'h2;
    localparam logic [1:0] PAIR_ALL   = 2'h0;
    localparam logic [1:0] PAIR_NORD  = 2'h1;
    // application reset address
    localparam logic [15:0] APP_RESET_ADDR = 16'h0000;
    // programming time
    localparam int CLK_MHZ        = 20;
    localparam int PROG_TIME_US   = 4000;
    localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;

    // fetch/load request from the cpu
    typedef struct packed {
        logic        valid;
        logic        is_load;
        logic [15:0] addr;
        logic [15:0] pc;
    } bfp_read_req_t;

    // store-program request from the cpu
    typedef struct packed {
        logic        valid;
        logic        erase;
        logic        write;
        logic        lock_set;
        logic [3:0]  lock_data;
        logic [15:0] addr;
        logic [15:0] pc;
    } bfp_store_req_t;

    // command to the flash array
    typedef struct packed {
        logic        start;
        logic        erase;
        logic [15:0] addr;
    } bfp_flash_cmd_t;

    // operation state
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONC   = 3'b010,
        ST_NOCONC = 3'b100
    } bfp_state_t;
endpackage

//--- logic/bfp_protect.sv
// boot flash read-while-write arbitration and boot lock protection
//
// Summary of operation
// - shared-region programming: only other region read
// - busy flag set while shared region blocked
// - loader region always inside stall region
// - stall-region programming stalls cpu whole operation
// - two independent lock pairs, app and loader
// - locks set by software/ports, erase clears
// - general write lock ignores store-program
// - general read/write lock ignores load/store
// - app mode 1: no restriction
// - app mode 2: store refused, load allowed
// - app mode 3: store and loader-load refused
// - app mode 4: loader-load refused only
// - app modes 3,4: mask irq in app
// - loader mode 1: no restriction
// - loader mode 2: store refused
// - loader mode 3: store and app-load refused
// - loader mode 4: app-load refused; irq mask
// - programmed boot fuse: reset at loader start
// - running code cannot alter fuses
// - store-program works only from loader code
// - fuse 0 loader vector, 1 address zero
//
// regions: below NOCONC_START lies the shared region, which may
// be programmed while the cpu keeps running on other code; from
// NOCONC_START up lies the stall region, whose top part from
// BOOT_START upward is the loader region.
// programming the shared region sets the busy flag and leaves the
// cpu running on stall-region code; programming the stall region
// holds cpu_stall for the whole operation, so nothing is read.
// an operation ends on flash_done or, should the array never
// answer, when the PROG_CNT fallback timer runs out.
//
// lock pairs: a programmed bit reads as zero. the low bit of a
// pair guards stores into its region, the high bit guards loads
// into it from code in the other region. bits only move to zero;
// only ext_chip_erase or rst_n brings them back to all ones.
//
// register map (byte offsets, one word each):
//   ctrl   0x000  bit0 write 1 re-opens the shared region when idle,
//                 bit1 interrupt vectors sit in the loader region
//   status 0x004  bit0 busy, bit1 stall, bit2 op active,
//                 bit3 store refused (sticky, write 1 to clear)
//   lock   0x008  read only, [1:0] application pair, [3:2] loader
//   fuse   0x00c  read only, bit0 synchronised boot select fuse
// the bus never waits; prdata is loaded in the setup cycle.
//
// timing: a legal store is taken at the edge where st_req is seen;
// st_accept answers in that cycle and flash_cmd.start pulses in
// the next. reads are answered in the cycle they are asked.
// stores arriving while an operation runs are refused, so only one
// operation is ever in flight.
// limitation: irq_from_app is not used; vector location comes from
// the ctrl register and the pc shown on the read port.
//
// the boot select fuse is a pin: three flops, taken once two
// stages agree, so a glitch never moves the vector. no register
// path writes it.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
module bfp_protect
    import bfp_pkg::*;
#(
    parameter int          ADDR_W      = 16,
    parameter logic [15:0] NOCONC_START = 16'h1800,
    parameter logic [15:0] BOOT_START  = 16'h1c00,
    parameter int          PROG_CNT    = PROG_CYCLES
) (
    // clock and reset
    input  wire logic           mclk,
    input  wire logic           rst_n,
    // apb slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    // cpu read and store requests
    input  wire bfp_read_req_t  rd_req,
    output logic                rd_grant,
    output logic                rd_denied,
    input  wire bfp_store_req_t st_req,
    output logic                st_accept,
    output logic                cpu_stall,
    input  wire logic           irq_from_app,
    output logic                irq_inhibit,
    // reset vector
    output logic      [15:0]    reset_vector,
    // flash array
    output bfp_flash_cmd_t      flash_cmd,
    input  wire logic           flash_done,
    // programming port (serial/parallel), fuse pins
    input  wire logic           ext_lock_prog,
    input  wire logic [3:0]     ext_lock_data,
    input  wire logic           ext_chip_erase,
    input  wire logic           boot_reset_select_fuse
);

    // elaboration checks: parameters the logic cannot serve
    if (BOOT_START < NOCONC_START) begin : g_bad_boot
        // loader region must sit in the stall region
        $error("boot region outside stall region");
    end
    if (PROG_CNT < 1) begin : g_bad_cnt
        $error("program count too small");
    end
    if (ADDR_W != 16) begin : g_bad_width
        // request structs and region compares are fixed at 16 bits
        $error("address width must be 16");
    end

    bfp_state_t  state;
    logic [3:0]  lock_bits;
    logic        concurrent_region_busy_flag;
    logic        vec_in_boot;
    logic        refused;
    logic [31:0] prog_cnt;
    logic [2:0]  fuse_sync;
    logic        fuse_q;

    // region decode helpers; shared region is all below the stall
    // region, loader region the top of the stall region
    function automatic logic in_conc(input logic [15:0] a);
        in_conc = (a < NOCONC_START);
    endfunction
    function automatic logic in_boot(input logic [15:0] a);
        in_boot = (a >= BOOT_START);
    endfunction

    logic [1:0] app_pair;
    logic [1:0] ldr_pair;
    assign app_pair = {lock_bits[LK_APP_HI], lock_bits[LK_APP_LO]};
    assign ldr_pair = {lock_bits[LK_LDR_HI], lock_bits[LK_LDR_LO]};

    // store legality; general lock levels play no part here
    logic st_from_boot;
    logic st_tgt_boot;
    logic st_wr_blocked;
    logic st_legal;
    assign st_from_boot  = in_boot(st_req.pc);
    assign st_tgt_boot   = in_boot(st_req.addr);
    // app pair: modes 2 and 3 forbid store; modes 1 and 4 allow
    // loader pair: modes 2 and 3 forbid store
    // pair code {hi,lo}: 11 free, 10 no store, 00 no store and no
    // cross load, 01 no cross load; store legality reads lo only
    assign st_wr_blocked = st_tgt_boot ? !ldr_pair[0] : !app_pair[0];
    assign st_legal      = st_req.valid && st_from_boot && !st_req.lock_set
                           && (st_req.erase || st_req.write) && !st_wr_blocked
                           && (state == ST_IDLE);

    // load legality across regions
    logic rd_from_boot;
    logic rd_tgt_boot;
    logic rd_lpm_block;
    logic rd_region_ok;
    assign rd_from_boot = in_boot(rd_req.pc);
    assign rd_tgt_boot  = in_boot(rd_req.addr);
    always_comb begin
        rd_lpm_block = 1'b0;
        if (rd_req.is_load && rd_from_boot && !rd_tgt_boot) begin
            rd_lpm_block = !app_pair[1];
        end else if (rd_req.is_load && !rd_from_boot && rd_tgt_boot) begin
            rd_lpm_block = !ldr_pair[1];
        end
    end
    // shared region unreadable while busy; nothing during stall op.
    // busy is left for software to clear: half-programmed code
    // would hand the cpu garbage
    assign rd_region_ok = !(concurrent_region_busy_flag && in_conc(rd_req.addr));

    // cpu-side outputs; stall straight from the state register so
    // it cannot glitch while the array is being written
    assign cpu_stall = (state == ST_NOCONC);
    assign rd_grant  = rd_req.valid && !cpu_stall && rd_region_ok && !rd_lpm_block;
    assign rd_denied = rd_req.valid && !cpu_stall && !(rd_region_ok && !rd_lpm_block);
    assign st_accept = st_legal;

    // interrupt inhibit depends on where the vectors live; the pc
    // on the read port tells which region is executing, so the
    // inhibit follows the cpu from one region to the other
    always_comb begin
        irq_inhibit = 1'b0;
        if (vec_in_boot && !in_boot(rd_req.pc) && !app_pair[1]) begin
            irq_inhibit = 1'b1;
        end else if (!vec_in_boot && in_boot(rd_req.pc) && !ldr_pair[1]) begin
            irq_inhibit = 1'b1;
        end
    end

    // fuse pin sync: change counts when stages two and three agree
    // resets to unprogrammed so a reset boots at address zero until
    // the pin has been seen
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fuse_sync <= 3'h7;
            fuse_q    <= 1'b1;
        end else begin
            fuse_sync <= {fuse_sync[1:0], boot_reset_select_fuse};
            if (fuse_sync[2] == fuse_sync[1]) begin
                fuse_q <= fuse_sync[2];
            end
        end
    end
    // only the pin feeds the fuse; no software path exists
    assign reset_vector = fuse_q ? APP_RESET_ADDR : BOOT_START;

    // programming operation sequencer
    // the timer is a safety net only; a live array ends the op
    // with flash_done long before it runs out
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= ST_IDLE;
            flash_cmd <= '0;
            prog_cnt  <= '0;
        end else begin
            flash_cmd.start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (st_legal) begin
                        flash_cmd.start <= 1'b1;
                        flash_cmd.erase <= st_req.erase;
                        flash_cmd.addr  <= st_req.addr;
                        prog_cnt        <= 32'(PROG_CNT);
                        state <= in_conc(st_req.addr) ? ST_CONC : ST_NOCONC;
                    end
                end
                ST_CONC, ST_NOCONC: begin
                    // done by array flag or by the fallback timer
                    if (flash_done || prog_cnt <= 32'd1) begin
                        state <= ST_IDLE;
                    end else begin
                        prog_cnt <= prog_cnt - 32'd1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // busy flag: hardware set wins over software clear
    // clear only when idle: re-opening mid-operation would let the
    // cpu read a page that is still being written
    logic apb_wr;
    logic apb_rd;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            concurrent_region_busy_flag <= 1'b0;
        end else if (st_legal && in_conc(st_req.addr)) begin
            concurrent_region_busy_flag <= 1'b1;
        end else if (apb_wr && paddr == OFF_CTRL && pwdata[CTRL_REENABLE]
                     && state == ST_IDLE) begin
            concurrent_region_busy_flag <= 1'b0;
        end
    end

    // lock bits: only programming (to 0) by software or port; erase restores
    // anding means a bit once cleared stays cleared, whatever later
    // data is written; software store wins a tie with the port
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lock_bits <= LOCK_RESET;
        end else if (ext_chip_erase) begin
            lock_bits <= LOCK_RESET;
        end else begin
            if (st_req.valid && st_req.lock_set && st_from_boot && state == ST_IDLE) begin
                lock_bits <= lock_bits & st_req.lock_data;
            end else if (ext_lock_prog) begin
                lock_bits <= lock_bits & ext_lock_data;
            end
        end
    end

    // control bits and sticky refusal indicator
    // refusal set wins over a same-cycle software clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vec_in_boot <= 1'b0;
            refused     <= 1'b0;
        end else begin
            if (apb_wr && paddr == OFF_CTRL) begin
                vec_in_boot <= pwdata[CTRL_VEC_BOOT];
            end
            if (st_req.valid && !st_req.lock_set && !st_legal && state == ST_IDLE) begin
                refused <= 1'b1;
            end else if (apb_wr && paddr == OFF_STATUS && pwdata[ST_REFUSED]) begin
                refused <= 1'b0;
            end
        end
    end

    // apb read mux, registered data; zero wait states
    // a miss answers with pslverr and reads back zero
    logic reg_hit;
    assign reg_hit = (paddr == OFF_CTRL) || (paddr == OFF_STATUS)
                     || (paddr == OFF_LOCK) || (paddr == OFF_FUSE);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !reg_hit;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFF_CTRL:   prdata <= {30'h0, vec_in_boot, 1'b0};
                OFF_STATUS: prdata <= {28'h0, refused, state != ST_IDLE,
                                       cpu_stall, concurrent_region_busy_flag};
                OFF_LOCK:   prdata <= {28'h0, lock_bits};
                OFF_FUSE:   prdata <= {31'h0, fuse_q};
                default:    prdata <= '0;
            endcase
        end
    end

endmodule

//--- sim/bfp_protect_props.sv
// port checker for the boot flash protection block
`timescale 1ns/10ps
module bfp_protect_props
    import bfp_pkg::*;
#(
    parameter logic [15:0] NOCONC_START = 16'h1800,
    parameter logic [15:0] BOOT_START = 16'h1c00,
    parameter int          PROG_CNT   = PROG_CYCLES
) (
    // clock, reset, bus
    input wire logic           mclk,
    input wire logic           rst_n,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pready,
    // cpu side
    input wire bfp_read_req_t  rd_req,
    input wire logic           rd_grant,
    input wire bfp_store_req_t st_req,
    input wire logic           st_accept,
    input wire logic           cpu_stall,
    input wire logic [15:0]    reset_vector,
    // flash and programming port
    input wire bfp_flash_cmd_t flash_cmd,
    input wire logic           flash_done,
    input wire logic           ext_lock_prog,
    input wire logic [3:0]     ext_lock_data,
    input wire logic           ext_chip_erase,
    input wire logic           boot_reset_select_fuse
);
    logic [3:0]  lk;
    logic [31:0] sc;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // shadow of the lock bits; lock set only from loader code
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) lk <= LOCK_RESET;
        else if (ext_chip_erase) lk <= LOCK_RESET;
        else if (ext_lock_prog) lk <= lk & ext_lock_data;
        else if (st_req.valid && st_req.lock_set && st_req.pc >= BOOT_START) begin
            lk <= lk & st_req.lock_data;
        end
    end
    // stall length, bounded by the fallback timer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) sc <= 32'h0;
        else sc <= cpu_stall ? sc + 32'h1 : 32'h0;
    end
    sequence s_conc_go;
        st_accept && st_req.addr < NOCONC_START ##1 flash_cmd.start && !cpu_stall;
    endsequence
    sequence s_noconc_go;
        st_accept && st_req.addr >= NOCONC_START ##1 flash_cmd.start && cpu_stall;
    endsequence
    a_conc_open: assert property (st_accept && st_req.addr < NOCONC_START |-> s_conc_go)
        else $error("shared program did not start without stall");
    a_conc_blocked: assert property (s_conc_go ##0 (rd_req.valid && rd_req.addr < NOCONC_START)
        |-> !rd_grant) else $error("busy region was read");
    a_noconc_stall: assert property (st_accept && st_req.addr >= NOCONC_START |-> s_noconc_go)
        else $error("stall-region program did not stall");
    a_stall_blind: assert property (cpu_stall |-> !rd_grant)
        else $error("read served during stall");
    a_stall_end: assert property (cpu_stall && flash_done |=> !cpu_stall)
        else $error("stall outlived flash done");
    a_stall_bound: assert property (sc <= PROG_CNT + 2)
        else $error("stall too long");
    a_loader_only: assert property (st_accept |-> st_req.pc >= BOOT_START)
        else $error("store accepted outside loader");
    a_store_lock: assert property (st_accept |->
        (st_req.addr < BOOT_START ? lk[LK_APP_LO] : lk[LK_LDR_LO]))
        else $error("store accepted into locked region");
    a_load_app: assert property (rd_req.valid && rd_req.is_load && rd_req.pc >= BOOT_START
        && rd_req.addr < BOOT_START && !lk[LK_APP_HI] |-> !rd_grant)
        else $error("locked application load served");
    a_load_ldr: assert property (rd_req.valid && rd_req.is_load && rd_req.pc < BOOT_START
        && rd_req.addr >= BOOT_START && !lk[LK_LDR_HI] |-> !rd_grant)
        else $error("locked loader load served");
    a_refuse_quiet: assert property (st_req.valid && !st_accept && !cpu_stall
        |=> !flash_cmd.start && !cpu_stall) else $error("refused store had effect");
    a_apb_ready: assert property (psel && penable |-> pready) else $error("apb not ready");
    a_boot_vector: assert property ($stable(boot_reset_select_fuse)[*5] |=> reset_vector ==
        ($past(boot_reset_select_fuse) ? APP_RESET_ADDR : BOOT_START))
        else $error("reset vector mismatch");
endmodule

bind bfp_protect bfp_protect_props #(.NOCONC_START(NOCONC_START), .BOOT_START(BOOT_START),
    .PROG_CNT(PROG_CNT)) i_bfp_protect_props (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pready(pready), .rd_req(rd_req), .rd_grant(rd_grant),
    .st_req(st_req), .st_accept(st_accept), .cpu_stall(cpu_stall),
    .reset_vector(reset_vector), .flash_cmd(flash_cmd), .flash_done(flash_done),
    .ext_lock_prog(ext_lock_prog), .ext_lock_data(ext_lock_data),
    .ext_chip_erase(ext_chip_erase), .boot_reset_select_fuse(boot_reset_select_fuse));

//--- sim/bfp_flash_model.sv
// flash array stand-in, answers a program command after a set latency
`timescale 1ns/10ps
module bfp_flash_model
    import bfp_pkg::*;
(
    // clock and reset
    input  wire logic           mclk,
    input  wire logic           rst_n,
    // command and answer
    input  wire bfp_flash_cmd_t flash_cmd,
    input  wire logic [4:0]     lat,
    output logic                flash_done
);
    logic [4:0] cnt;
    // long latency lets the block's fallback timer end the operation
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 5'h0;
            flash_done <= 1'h0;
        end else begin
            flash_done <= (cnt == 5'h1);
            if (flash_cmd.start) cnt <= lat;
            else if (cnt != 5'h0) cnt <= cnt - 5'h1;
        end
    end
endmodule

//--- sim/tb.sv
// self-checking bench for the boot flash protection block
`timescale 1ns/10ps
module tb import bfp_pkg::*; ;
    typedef struct packed {
        logic [3:0]  lk;
        logic [15:0] a;
        logic [15:0] pc;
        logic        rd;
        logic        st;
    } bfp_row_t;
    localparam logic [15:0] BS = 16'h1c00;
    // lock setting, load address, load pc, grant, store accept
    bfp_row_t rows [8] = '{'{4'hf, 16'h0100, BS, 1'h1, 1'h1}, '{4'he, 16'h0100, BS, 1'h1, 1'h0},
        '{4'hc, 16'h0100, BS, 1'h0, 1'h0}, '{4'hd, 16'h0100, BS, 1'h0, 1'h1},
        '{4'hf, BS, 16'h0, 1'h1, 1'h1}, '{4'hb, BS, 16'h0, 1'h1, 1'h0},
        '{4'h3, BS, 16'h0, 1'h0, 1'h0}, '{4'h7, BS, 16'h0, 1'h0, 1'h1}};
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, rd_grant, st_accept, cpu_stall;
    logic flash_done, ext_lock_prog, ext_chip_erase, fuse, acc, err, rd_denied, irq_inhibit;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rdat;
    logic [15:0]    reset_vector;
    logic [3:0]     ext_lock_data;
    logic [4:0]     lat;
    bfp_read_req_t  rd_req;
    bfp_store_req_t st_req;
    bfp_flash_cmd_t flash_cmd;
    int             fail_count, comparisons;
    bfp_protect #(.PROG_CNT(8)) i_bfp_protect (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rd_req(rd_req), .rd_grant(rd_grant),
        .rd_denied(rd_denied), .st_req(st_req), .st_accept(st_accept), .cpu_stall(cpu_stall),
        .irq_from_app(1'h0), .irq_inhibit(irq_inhibit), .reset_vector(reset_vector),
        .flash_cmd(flash_cmd), .flash_done(flash_done), .ext_lock_prog(ext_lock_prog),
        .ext_lock_data(ext_lock_data), .ext_chip_erase(ext_chip_erase),
        .boot_reset_select_fuse(fuse));
    bfp_flash_model i_bfp_flash_model (.mclk(mclk), .rst_n(rst_n), .flash_cmd(flash_cmd),
        .lat(lat), .flash_done(flash_done));
    // clock
    initial begin
        mclk = 1'h0;
        forever #25 mclk = ~mclk;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task close_out;
        if (fail_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one apb transfer; read data and error taken at the ready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task store(input logic [15:0] a, input logic [15:0] pc, input logic ls);
        @(posedge mclk);
        st_req <= '{1'h1, !ls, 1'h0, ls, 4'h0, a, pc};
        @(negedge mclk);
        acc = st_accept;
        @(posedge mclk);
        st_req <= '0;
    endtask
    task rd(input logic [15:0] a, input logic [15:0] pc, input logic e);
        @(posedge mclk);
        rd_req <= '{1'h1, 1'h1, a, pc};
        @(negedge mclk);
        chk("rd_grant", {31'h0, e}, {31'h0, rd_grant});
    endtask
    // erase first: programming can only clear lock bits
    task lockprog(input logic [3:0] d);
        @(posedge mclk);
        ext_chip_erase <= 1'h1;
        @(posedge mclk);
        ext_chip_erase <= 1'h0;
        ext_lock_prog <= 1'h1;
        ext_lock_data <= d;
        @(posedge mclk);
        ext_lock_prog <= 1'h0;
    endtask
    task idle;
        rdat = 32'h4;
        for (int i = 0; i < 40 && rdat[ST_OP_ACTIVE]; i++) apb(1'h0, OFF_STATUS, 32'h0);
    endtask
    // watchdog
    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        close_out;
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, ext_lock_prog, ext_chip_erase} = '0;
        {rd_req, st_req, ext_lock_data} = '0;
        fuse = 1'h1;
        lat = 5'h3;
        repeat (10) @(posedge mclk);
        rst_n <= 1'h1;
        apb(1'h0, OFF_LOCK, 32'h0);
        chk("lock reset", {28'h0, LOCK_RESET}, rdat);
        foreach (rows[i]) begin
            lockprog(rows[i].lk);
            apb(1'h0, OFF_LOCK, 32'h0);
            chk("lock", {28'h0, rows[i].lk}, rdat);
            rd(rows[i].a, rows[i].pc, rows[i].rd);
            chk("rd_denied", {31'h0, !rows[i].rd}, {31'h0, rd_denied});
            store(rows[i].a, BS, 1'h0);
            chk("accept", {31'h0, rows[i].st}, {31'h0, acc});
            idle;
            apb(1'h1, OFF_CTRL, 32'h1);
        end
        apb(1'h1, OFF_STATUS, 32'h8);
        lockprog(4'hf);
        rd(16'h0100, BS, 1'h1);
        store(16'h0100, BS, 1'h0);
        rd(16'h0100, BS, 1'h0);
        rd(16'h1800, BS, 1'h1);
        idle;
        apb(1'h0, OFF_STATUS, 32'h0);
        chk("busy", 32'h1, rdat);
        apb(1'h1, OFF_CTRL, 32'h1);
        rd(16'h0100, BS, 1'h1);
        store(16'h0100, 16'h0100, 1'h0);
        chk("foreign store", 32'h0, {31'h0, acc});
        apb(1'h0, OFF_STATUS, 32'h0);
        chk("refused", 32'h8, rdat);
        lat <= 5'h0c;
        store(16'h1800, BS, 1'h0);
        rd(16'h0100, BS, 1'h0);
        chk("stall", 32'h1, {31'h0, cpu_stall});
        idle;
        chk("stall end", 32'h0, {31'h0, cpu_stall});
        store(16'h0, BS, 1'h1);
        apb(1'h0, OFF_LOCK, 32'h0);
        chk("lock set", 32'h0, rdat);
        chk("irq inhibit", 32'h1, {31'h0, irq_inhibit});
        apb(1'h1, OFF_CTRL, 32'h2);
        @(negedge mclk);
        chk("irq loader", 32'h0, {31'h0, irq_inhibit});
        rd(16'h0100, 16'h0100, 1'h1);
        chk("irq app", 32'h1, {31'h0, irq_inhibit});
        apb(1'h1, OFF_FUSE, 32'h0);
        apb(1'h0, 12'h010, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        chk("vector", 32'h0, {16'h0, reset_vector});
        fuse <= 1'h0;
        repeat (6) @(posedge mclk);
        chk("boot vector", {16'h0, BS}, {16'h0, reset_vector});
        rst_n <= 1'h0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (6) @(posedge mclk);
        chk("vector again", {16'h0, BS}, {16'h0, reset_vector});
        close_out;
    end
endmodule
